//--- pdcd_top.sv
// PLL control, switch status and five device clock dividers
// Function
// - audio serial divider is 9 bits, ratio field plus one, 1..512.
// - pixel divider is 11 bits, ratio field plus one, 1..2048.
// - card divider is 5 bits, ratio field plus one, 1..32.
// - sync serial divider is 4 bits, ratio field plus one, 1..16.
// - camera master divider is 8 bits, ratio field plus one, 1..256.
// - reserved bits ignore writes and read zero.
// - pll control resets to 0x28080011.
// - feedback divider is bits 31:23, read and write.
// - input divider is bits 22:18, read and write.
// - output divider code 0,1,2,3 divides by 1,2,2,4.
// - stable flag bit 10 is one only when enabled and settled.
// - enable starts locking; when stable, dividers use PLL unless bypassed.
// - disable shuts PLL and routes dividers to crystal, bypass ignored.
// - bypass routes to crystal while enabled; no effect when disabled.
// - stabilize wait counted in real-time ticks after change or enable.
// - switch status register resets to 0x80000000.
// - bits 31,30,29 show off, bypass and on states.
// - bit 28 set by hardware when enable or change finished.
// - bit 27 set when main divider change finished; written to zero.
// - bit 26 set when PLL and crystal switch finished.
// - bit 2 set stops all main clocks during a main divider change.
// - bit 1 picks slow or fast PLL and crystal switching.
// - bit 0 picks slow or fast main frequency change.
// - change enable applies divider writes at once, else at next sequence.
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
`include "pdcd_map.svh"
module pdcd_top (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        sys_rst_i,
    // Avalon-MM slave
    input  wire logic [2:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Clock source pins
    input  wire logic        crystal_clock_i,
    input  wire logic        pll_clock_i,
    input  wire logic        real_time_clock_source_i,
    // Main clock controller
    input  wire logic        change_enable_i,
    input  wire logic        main_div_busy_i,
    input  wire logic        main_div_done_i,
    // PLL macro settings
    output logic      [8:0]  feedback_divider_o,
    output logic      [4:0]  input_divider_o,
    output logic      [1:0]  output_divider_o,
    output logic             pll_power_o,
    // Mode and clock routing
    output logic             source_is_pll_o,
    output logic             main_clocks_stop_o,
    output logic             switch_speed_mode_o,
    output logic             freq_change_speed_mode_o,
    // Device clock pulses: audio, pixel, card, sync serial, camera
    output logic      [4:0]  dev_clk_tick_o
);
    localparam int NDIV = 5;
    localparam int WMAX = `PDCD_W_DIV_MAX;

    logic [31:0]            div_cfg [NDIV];
    logic [WMAX-1:0]        div_act [NDIV];
    logic [31:0]            pll_control;
    logic                   stop_on_change_mode;
    logic                   switch_speed_mode;
    logic                   freq_change_speed_mode;
    logic                   pll_change_done;
    logic                   freq_change_done;
    logic                   switch_done;
    pdcd_pkg::pdcd_pll_state_t pll_state;
    logic [7:0]             settle_cnt;
    logic                   sel_pll;
    logic [7:0]             switch_cnt;
    logic [1:0]             od_cnt;
    logic                   pll_src_tick;
    logic                   xtal_rise;
    logic                   pll_rise;
    logic                   rtc_rise;
    logic                   bus_req;
    logic                   bus_take;
    logic                   wr_ok;
    logic                   ctl_wr;
    logic                   stat_wr;
    logic                   mult_change;
    logic                   enable_rise;
    logic                   seq_start;
    logic                   pll_enable;
    logic                   pll_bypass;
    logic                   pll_stable_flag;
    logic                   want_pll;
    logic                   switch_finish;
    logic                   lock_finish;
    logic [31:0]            next_rdata;
    logic [31:0]            status_word;
    logic [4:0]             div_ticks;

    // Field width of each divider register
    function automatic logic [31:0] div_mask(input int idx);
        int w;
        w = (idx == 0) ? `PDCD_W_AUDIO :
            (idx == 1) ? `PDCD_W_PIXEL :
            (idx == 2) ? `PDCD_W_CARD  :
            (idx == 3) ? `PDCD_W_SYNC  : `PDCD_W_CAMERA;
        div_mask = (32'h0000_0001 << w) - 32'h0000_0001;
    endfunction : div_mask

    function automatic logic [31:0] div_reset(input int idx);
        div_reset = (idx == 0) ? `PDCD_RST_AUDIO :
                    (idx == 1) ? `PDCD_RST_PIXEL :
                    (idx == 2) ? `PDCD_RST_CARD  :
                    (idx == 3) ? `PDCD_RST_SYNC  : `PDCD_RST_CAMERA;
    endfunction : div_reset

    // Source pins sampled into sysclk; PLL pin must stay under ~66 MHz
    pdcd_edge_sync u_xtal_sync (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (crystal_clock_i),
        .rise_o    (xtal_rise)
    );

    pdcd_edge_sync u_pll_sync (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (pll_clock_i),
        .rise_o    (pll_rise)
    );

    pdcd_edge_sync u_rtc_sync (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (real_time_clock_source_i),
        .rise_o    (rtc_rise)
    );

    // Bus decode: one wait cycle, then the access completes
    assign bus_req  = avs_read_i | avs_write_i;
    assign bus_take = bus_req & ~avs_waitrequest_o;
    assign wr_ok    = avs_write_i & bus_take
                      & (avs_byteenable_i == 4'hF);
    assign ctl_wr   = wr_ok & (avs_address_i == `PDCD_IDX_PLL_CTL);
    assign stat_wr  = wr_ok & (avs_address_i == `PDCD_IDX_PLL_STAT);

    assign pll_enable      = pll_control[`PDCD_CTL_ENABLE];
    assign pll_bypass      = pll_control[`PDCD_CTL_BYPASS];
    assign pll_stable_flag = (pll_state == pdcd_pkg::PDCD_PLL_STABLE);

    // A multiplier change restarts settling only while running
    assign mult_change = ctl_wr & pll_enable
        & avs_writedata_i[`PDCD_CTL_ENABLE]
        & (avs_writedata_i[`PDCD_CTL_FB_HI:`PDCD_CTL_OD_LO]
           != pll_control[`PDCD_CTL_FB_HI:`PDCD_CTL_OD_LO]);
    assign enable_rise = ctl_wr & ~pll_enable
                         & avs_writedata_i[`PDCD_CTL_ENABLE];
    assign seq_start   = mult_change | enable_rise;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
        end
    end

    // Divider registers and their active copies
    genvar g;
    generate
        for (g = 0; g < NDIV; g = g + 1) begin : g_div
            pdcd_div_if #(.W(WMAX)) link ();

            always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    div_cfg[g] <= div_reset(g);
                end else if (wr_ok && avs_address_i == 3'(g)) begin
                    div_cfg[g] <= avs_writedata_i & div_mask(g);
                end
            end

            // Applied at once, or held until the next sequence
            always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    div_act[g] <= WMAX'(div_reset(g));
                end else if (change_enable_i || seq_start) begin
                    div_act[g] <= div_cfg[g][WMAX-1:0];
                end
            end

            assign link.ratio    = div_act[g];
            assign link.src_tick = sel_pll ? pll_src_tick : xtal_rise;
            assign div_ticks[g]  = link.div_tick;

            pdcd_clk_div #(.W(WMAX)) u_div (
                .clk_sys_i (clk_sys_i),
                .sys_rst_i (sys_rst_i),
                .link      (link.div)
            );
        end
    endgenerate

    assign dev_clk_tick_o = div_ticks;

    // PLL control register
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pll_control <= `PDCD_RST_PLL_CTL;
        end else if (ctl_wr) begin
            pll_control <= avs_writedata_i & `PDCD_CTL_WR_MASK;
        end
    end

    // Lock state: settle for stabilize_time real-time ticks
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pll_state  <= pdcd_pkg::PDCD_PLL_OFF;
            settle_cnt <= 8'h00;
        end else if (ctl_wr && !avs_writedata_i[`PDCD_CTL_ENABLE]) begin
            pll_state  <= pdcd_pkg::PDCD_PLL_OFF;
            settle_cnt <= 8'h00;
        end else if (seq_start) begin
            pll_state  <= pdcd_pkg::PDCD_PLL_LOCK;
            settle_cnt <= 8'h00;
        end else begin
            unique case (pll_state)
                pdcd_pkg::PDCD_PLL_OFF: begin
                    settle_cnt <= 8'h00;
                end
                pdcd_pkg::PDCD_PLL_LOCK: begin
                    if (lock_finish) begin
                        pll_state <= pdcd_pkg::PDCD_PLL_STABLE;
                    end else if (rtc_rise) begin
                        settle_cnt <= settle_cnt + 8'h01;
                    end
                end
                pdcd_pkg::PDCD_PLL_STABLE: begin
                    settle_cnt <= settle_cnt;
                end
                default: begin
                    pll_state <= pdcd_pkg::PDCD_PLL_OFF;
                end
            endcase
        end
    end

    assign lock_finish = (pll_state == pdcd_pkg::PDCD_PLL_LOCK)
        && (settle_cnt >= pll_control[`PDCD_CTL_ST_HI:`PDCD_CTL_ST_LO]);

    // Output divider applied to the raw PLL ticks
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            od_cnt       <= 2'h0;
            pll_src_tick <= 1'b0;
        end else begin
            pll_src_tick <= 1'b0;
            if (pll_rise) begin
                unique case (output_divider_o)
                    2'h0: begin
                        pll_src_tick <= 1'b1;
                    end
                    2'h1, 2'h2: begin
                        od_cnt       <= {1'b0, ~od_cnt[0]};
                        pll_src_tick <= od_cnt[0];
                    end
                    2'h3: begin
                        od_cnt       <= od_cnt + 2'h1;
                        pll_src_tick <= (od_cnt == 2'h3);
                    end
                endcase
            end
        end
    end

    // Source switch, slow or fast depending on mode
    assign want_pll = pll_enable & pll_stable_flag & ~pll_bypass;
    assign switch_finish = (want_pll != sel_pll) && (switch_cnt >=
        (switch_speed_mode ? `PDCD_SWITCH_FAST_CYC
                           : `PDCD_SWITCH_SLOW_CYC));

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sel_pll    <= 1'b0;
            switch_cnt <= 8'h00;
        end else if (!pll_enable && sel_pll) begin
            sel_pll    <= 1'b0;
            switch_cnt <= 8'h00;
        end else if (want_pll == sel_pll) begin
            switch_cnt <= 8'h00;
        end else if (switch_finish) begin
            sel_pll    <= want_pll;
            switch_cnt <= 8'h00;
        end else begin
            switch_cnt <= switch_cnt + 8'h01;
        end
    end

    // Mode bits of the switch and status register
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stop_on_change_mode    <= 1'b0;
            switch_speed_mode      <= 1'b0;
            freq_change_speed_mode <= 1'b0;
        end else if (stat_wr) begin
            stop_on_change_mode    <= avs_writedata_i[`PDCD_ST_STOP_MODE];
            switch_speed_mode      <= avs_writedata_i[`PDCD_ST_SWITCH_SPEED];
            freq_change_speed_mode <= avs_writedata_i[`PDCD_ST_FREQ_SPEED];
        end
    end

    // Done bits: hardware set wins over a software write of zero
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pll_change_done <= 1'b0;
        end else begin
            pll_change_done <= lock_finish | (pll_change_done
                & ~(stat_wr & ~avs_writedata_i[`PDCD_ST_PLL_DONE]));
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            freq_change_done <= 1'b0;
        end else begin
            freq_change_done <= main_div_done_i | (freq_change_done
                & ~(stat_wr & ~avs_writedata_i[`PDCD_ST_FREQ_DONE]));
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            switch_done <= 1'b0;
        end else begin
            switch_done <= switch_finish
                | (!pll_enable && sel_pll) | (switch_done
                & ~(stat_wr & ~avs_writedata_i[`PDCD_ST_SWITCH_DONE]));
        end
    end

    // Read view of the switch and status register
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`PDCD_ST_OFF]    = (pll_state == pdcd_pkg::PDCD_PLL_OFF);
        status_word[`PDCD_ST_BYPASS] = pll_stable_flag & pll_bypass;
        status_word[`PDCD_ST_ON]     = pll_stable_flag & ~pll_bypass;
        status_word[`PDCD_ST_PLL_DONE]     = pll_change_done;
        status_word[`PDCD_ST_FREQ_DONE]    = freq_change_done;
        status_word[`PDCD_ST_SWITCH_DONE]  = switch_done;
        status_word[`PDCD_ST_STOP_MODE]    = stop_on_change_mode;
        status_word[`PDCD_ST_SWITCH_SPEED] = switch_speed_mode;
        status_word[`PDCD_ST_FREQ_SPEED]   = freq_change_speed_mode;
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (avs_address_i)
            `PDCD_IDX_AUDIO, `PDCD_IDX_PIXEL, `PDCD_IDX_CARD,
            `PDCD_IDX_SYNC, `PDCD_IDX_CAMERA: begin
                next_rdata = div_cfg[avs_address_i];
            end
            `PDCD_IDX_PLL_CTL: begin
                next_rdata = pll_control;
                next_rdata[`PDCD_CTL_STABLE] = pll_stable_flag;
            end
            `PDCD_IDX_PLL_STAT: begin
                next_rdata = status_word;
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && avs_waitrequest_o) begin
            avs_readdata_o <= next_rdata;
        end
    end

    // PLL macro settings and routing outputs
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            feedback_divider_o <= 9'h050;
            input_divider_o    <= 5'h02;
            output_divider_o   <= 2'h0;
            pll_power_o        <= 1'b0;
        end else begin
            feedback_divider_o <=
                pll_control[`PDCD_CTL_FB_HI:`PDCD_CTL_FB_LO];
            input_divider_o    <=
                pll_control[`PDCD_CTL_IN_HI:`PDCD_CTL_IN_LO];
            output_divider_o   <=
                pll_control[`PDCD_CTL_OD_HI:`PDCD_CTL_OD_LO];
            pll_power_o        <= pll_enable;
        end
    end

    // Stop mode gates the main clocks only during a change
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            source_is_pll_o          <= 1'b0;
            main_clocks_stop_o       <= 1'b0;
            switch_speed_mode_o      <= 1'b0;
            freq_change_speed_mode_o <= 1'b0;
        end else begin
            source_is_pll_o          <= sel_pll;
            main_clocks_stop_o       <= stop_on_change_mode
                                        & main_div_busy_i;
            switch_speed_mode_o      <= switch_speed_mode;
            freq_change_speed_mode_o <= freq_change_speed_mode;
        end
    end
endmodule : pdcd_top

//--- pdcd_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PDCD_MAP_SVH
`define PDCD_MAP_SVH

`define PDCD_IDX_AUDIO        3'h0
`define PDCD_IDX_PIXEL        3'h1
`define PDCD_IDX_CARD         3'h2
`define PDCD_IDX_SYNC         3'h3
`define PDCD_IDX_CAMERA       3'h4
`define PDCD_IDX_PLL_CTL      3'h5
`define PDCD_IDX_PLL_STAT     3'h6

`define PDCD_W_AUDIO          9
`define PDCD_W_PIXEL          11
`define PDCD_W_CARD           5
`define PDCD_W_SYNC           4
`define PDCD_W_CAMERA         8
`define PDCD_W_DIV_MAX        11

`define PDCD_RST_AUDIO        32'h0000_0004
`define PDCD_RST_PIXEL        32'h0000_0004
`define PDCD_RST_CARD         32'h0000_0000
`define PDCD_RST_SYNC         32'h0000_0000
`define PDCD_RST_CAMERA       32'h0000_0004
`define PDCD_RST_PLL_CTL      32'h2808_0011
`define PDCD_RST_PLL_STAT     32'h8000_0000

`define PDCD_CTL_WR_MASK      32'hFFFF_03FF
`define PDCD_CTL_FB_HI        31
`define PDCD_CTL_FB_LO        23
`define PDCD_CTL_IN_HI        22
`define PDCD_CTL_IN_LO        18
`define PDCD_CTL_OD_HI        17
`define PDCD_CTL_OD_LO        16
`define PDCD_CTL_STABLE       10
`define PDCD_CTL_BYPASS       9
`define PDCD_CTL_ENABLE       8
`define PDCD_CTL_ST_HI        7
`define PDCD_CTL_ST_LO        0

`define PDCD_ST_OFF           31
`define PDCD_ST_BYPASS        30
`define PDCD_ST_ON            29
`define PDCD_ST_PLL_DONE      28
`define PDCD_ST_FREQ_DONE     27
`define PDCD_ST_SWITCH_DONE   26
`define PDCD_ST_STOP_MODE     2
`define PDCD_ST_SWITCH_SPEED  1
`define PDCD_ST_FREQ_SPEED    0

`define PDCD_SWITCH_SLOW_CYC  8'h20
`define PDCD_SWITCH_FAST_CYC  8'h02
`endif

//--- pdcd_pkg.sv
// Types shared by the clock control block
package pdcd_pkg;
    typedef enum logic [1:0] {
        PDCD_PLL_OFF    = 2'b00,
        PDCD_PLL_LOCK   = 2'b01,
        PDCD_PLL_STABLE = 2'b10
    } pdcd_pll_state_t;
endpackage : pdcd_pkg

//--- pdcd_div_if.sv
// Link between the register block and one device clock divider
`timescale 1ns/10ps
interface pdcd_div_if #(parameter int W = 11);
    logic [W-1:0] ratio;
    logic         src_tick;
    logic         div_tick;
    modport ctrl (output ratio, output src_tick, input div_tick);
    modport div  (input ratio, input src_tick, output div_tick);
endinterface : pdcd_div_if

//--- pdcd_edge_sync.sv
// Two-stage synchroniser with rising-edge pulse
`timescale 1ns/10ps
module pdcd_edge_sync (
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic sys_rst_i,
    // Pin and pulse
    input  wire logic pin_i,
    output logic      rise_o
);
    logic meta;
    logic sync;
    logic last;

    // First stage feeds only the second
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta <= 1'b0;
            sync <= 1'b0;
            last <= 1'b0;
        end else begin
            meta <= pin_i;
            sync <= meta;
            last <= sync;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rise_o <= 1'b0;
        end else begin
            rise_o <= sync & ~last;
        end
    end
endmodule : pdcd_edge_sync

//--- pdcd_clk_div.sv
// One device clock divider, one output pulse per ratio+1 source ticks
`timescale 1ns/10ps
module pdcd_clk_div #(
    parameter int W = 11
) (
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic sys_rst_i,
    // Control link
    pdcd_div_if.div   link
);
    logic [W-1:0] count;
    logic [W-1:0] ratio_now;

    // New ratio taken only at a period boundary, so no runt period
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            count     <= '0;
            ratio_now <= '0;
        end else if (link.src_tick) begin
            if (count >= ratio_now) begin
                count     <= '0;
                ratio_now <= link.ratio;
            end else begin
                count <= count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            link.div_tick <= 1'b0;
        end else begin
            link.div_tick <= link.src_tick && (count >= ratio_now);
        end
    end
endmodule : pdcd_clk_div

//--- pdcd_top_properties.sv
// Port checks for the clock control block
`timescale 1ns/10ps
module pdcd_chk (
    // Watched ports
    input wire logic        clk_sys_i,
    input wire logic        sys_rst_i,
    input wire logic [2:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic        avs_waitrequest_o,
    input wire logic        main_div_busy_i,
    input wire logic [8:0]  feedback_divider_o,
    input wire logic [4:0]  input_divider_o,
    input wire logic [1:0]  output_divider_o,
    input wire logic        freq_change_speed_mode_o,
    input wire logic        pll_power_o,
    input wire logic        source_is_pll_o,
    input wire logic        main_clocks_stop_o,
    input wire logic        switch_speed_mode_o
);
    wire       req = avs_read_i | avs_write_i;
    wire       wr_ok = avs_write_i & ~avs_waitrequest_o & (&avs_byteenable_i);
    // Outputs follow the register one cycle later, hence the extra delay
    wire [16:0] cw = {avs_writedata_i[31:16], avs_writedata_i[8]};
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    AST_ACK_ONE: assert property (req && avs_waitrequest_o |=>
        !avs_waitrequest_o) else $error("no answer");
    AST_ACK_PULSE: assert property (!avs_waitrequest_o |=>
        avs_waitrequest_o) else $error("long answer");
    AST_FIELDS: assert property (wr_ok && avs_address_i == 3'h5
        |=> ##1 {feedback_divider_o, input_divider_o, output_divider_o,
        pll_power_o} == $past(cw, 2)) else $error("field");
    AST_HOLD: assert property (!(wr_ok && avs_address_i == 3'h5)
        |=> ##1 $stable({feedback_divider_o, input_divider_o,
        output_divider_o, pll_power_o})) else $error("drift");
    AST_MODES: assert property (wr_ok && avs_address_i == 3'h6
        |=> ##1 {switch_speed_mode_o, freq_change_speed_mode_o}
        == $past(avs_writedata_i[1:0], 2)) else $error("mode");
    AST_STOP: assert property (main_clocks_stop_o |->
        $past(main_div_busy_i)) else $error("stop");
    AST_OFF: assert property ($fell(pll_power_o) |-> ##[0:40]
        !source_is_pll_o) else $error("off");
    AST_SRC: assert property ($rose(source_is_pll_o) |->
        pll_power_o) else $error("source");
    cover property (wr_ok && avs_address_i == 3'h5);
    cover property ($rose(source_is_pll_o));
    cover property (main_clocks_stop_o);
endmodule : pdcd_chk
bind pdcd_top pdcd_chk u_chk (.*);

//--- pdcd_top_tb_top.sv
// Self-checking bench for the clock control block
`timescale 1ns/10ps
module pdcd_top_tb_top;
    logic        clk_sys_i = 0, sys_rst_i = 1, rd = 0, wr = 0, wt, src;
    logic        xtal = 0, pclk = 0, rtc = 0, busy = 0, done = 0;
    logic        ce = 0;
    logic [4:0]  tk;
    logic [2:0]  adr = 0;
    logic [3:0]  be = 4'hF;
    logic [31:0] wd = 0, rdat, v, exp_q [$];
    logic [31:0] rv [8] = '{4, 4, 0, 0, 4, 32'h2808_0011, 32'h8000_0000, 0};
    int          wid [5] = '{9, 11, 5, 4, 8};
    int          fails = 0, checks = 0, cyc = 0, seed = 32'h67E8DD3C;
    int          xn = 0, xl = 0, per_q [$];
    pdcd_top uut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wt), .crystal_clock_i(xtal), .pll_clock_i(pclk),
        .real_time_clock_source_i(rtc), .change_enable_i(ce),
        .main_div_busy_i(busy), .main_div_done_i(done), .pll_power_o(),
        .feedback_divider_o(), .input_divider_o(), .output_divider_o(),
        .source_is_pll_o(src), .main_clocks_stop_o(), .dev_clk_tick_o(tk),
        .switch_speed_mode_o(), .freq_change_speed_mode_o());
    initial forever #2.5 clk_sys_i = ~clk_sys_i;
    always #41.67 xtal = ~xtal;
    // Crystal edges counted to measure divider periods in source ticks
    always @(posedge xtal) xn++;
    always #10.4 pclk = ~pclk;
    // Fast settle tick keeps lock short
    always #250 rtc = ~rtc;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        fails += (seen !== exp) ? 1 : 0;
        if (seen !== exp)
            $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
    endtask : chk
    task print_verdict;
        fails += (cyc > 20000) ? 1 : 0;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    task bus(input logic w, input logic [2:0] a, input logic [31:0] d,
             input logic [3:0] b, input logic [31:0] e);
        if (!w)
            exp_q.push_back(e);
        {rd, wr, adr, wd, be} <= {!w, w, a, d, b};
        @(posedge clk_sys_i);
        while (wt !== 1'b0)
            @(posedge clk_sys_i);
        {rd, wr} <= 2'b00;
        @(posedge clk_sys_i);
    endtask : bus
    always @(posedge clk_sys_i) begin
        cyc++;
        if (rd && wt === 1'b0)
            chk(rdat, exp_q.pop_front());
        if (tk[3]) begin
            if (per_q.size() > 0)
                chk(xn - xl, per_q.pop_front());
            xl = xn;
        end
        if (cyc > 20000)
            print_verdict();
    end
    initial begin
        repeat (16) @(posedge clk_sys_i);
        sys_rst_i <= 0;
        for (int i = 0; i < 8; i++)
            bus(0, 3'(i), 0, 4'hF, rv[i]);
        for (int i = 0; i < 5; i++) begin
            v = $random(seed);
            bus(1, 3'(i), v, 4'hF, 0);
            bus(0, 3'(i), 0, 4'hF, v & ~(32'hFFFF_FFFF << wid[i]));
        end
        bus(1, 3'h4, ~v, 4'h3, 0);
        bus(0, 3'h4, 0, 4'hF, v & 32'hFF);
        bus(1, 3'h3, v, 4'hF, 0);
        repeat (2) @(posedge tk[3]);
        per_q.push_back(1);
        ce <= 1;
        // Old period may finish first, so skip two pulses
        repeat (3) @(posedge tk[3]);
        per_q.push_back(v[3:0] + 1);
        v = ($random(seed) & 32'hFFFF_FC00) | 32'h102;
        bus(1, 3'h5, v, 4'hF, 0);
        while (src !== 1'b1) @(posedge clk_sys_i);
        bus(0, 3'h5, 0, 4'hF, v & 32'hFFFF_03FF | 32'h400);
        bus(0, 3'h6, 0, 4'hF, 32'h3400_0000);
        bus(1, 3'h6, 32'h03FF_FFFF, 4'hF, 0);
        {busy, done} <= 2'b11;
        @(posedge clk_sys_i);
        {busy, done} <= 2'b00;
        bus(0, 3'h6, 0, 4'hF, 32'h2800_0007);
        bus(1, 3'h5, v | 32'h200, 4'hF, 0);
        while (src !== 1'b0) @(posedge clk_sys_i);
        bus(0, 3'h6, 0, 4'hF, 32'h4C00_0007);
        bus(1, 3'h5, v & 32'hFFFF_FEFF, 4'hF, 0);
        bus(0, 3'h5, 0, 4'hF, v & 32'hFFFF_02FF);
        print_verdict();
    end
endmodule : pdcd_top_tb_top
